// [design/rpm_pkg.sv]
// rpm_pkg: constants and carrier types of the radio power-mode sequencer
// assumes a 50 MHz master clock and a host-driven serial config clock
`default_nettype none
package rpm_pkg;
  // operating-mode codes carried in bits 7..5 of main_config_reg_zero
  localparam logic [2:0] MODE_SLEEP   = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_SYNTH   = 3'h2;
  localparam logic [2:0] MODE_RX      = 3'h3;
  localparam logic [2:0] MODE_TX      = 3'h4;
  localparam int unsigned MODE_MSB = 7;
  localparam int unsigned MODE_LSB = 5;
  // serial register addresses
  localparam logic [6:0] ADDR_MAIN_CONFIG_ZERO = 7'h00;
  localparam logic [6:0] ADDR_LOCK_CTRL        = 7'h0e;
  localparam int unsigned LOCK_STATUS_BIT  = 1;
  localparam int unsigned LOCK_DISABLE_BIT = 0;
  // reset values
  localparam logic [2:0] MODE_RESET     = 3'h0;
  localparam logic       LOCK_DIS_RESET = 1'b0;
  // serial frame: read flag, 7-bit address, 8-bit data, msb first
  localparam logic [3:0] FRAME_ADDR_LAST = 4'h7;
  localparam logic [3:0] FRAME_DATA_LAST = 4'hf;
  // timing, times in microseconds, counts derived from the clock rate
  localparam int unsigned MCLK_MHZ      = 50;
  localparam int unsigned XTAL_READY_US = 5000;
  localparam int unsigned PLL_LOCK_US   = 500;
  localparam int unsigned SEQ_TOTAL_US  = 6000;
  localparam int unsigned XTAL_READY_CYC = XTAL_READY_US * MCLK_MHZ;
  localparam int unsigned PLL_LOCK_CYC   = PLL_LOCK_US * MCLK_MHZ - 1;
  localparam int unsigned SEQ_TOTAL_CYC  = SEQ_TOTAL_US * MCLK_MHZ - 1;
  localparam int unsigned TIMER_W        = 20;

  typedef struct packed {
    logic       rd;
    logic [6:0] addr;
    logic [7:0] data;
  } rpm_cfg_frame_t;
endpackage : rpm_pkg
`default_nettype wire

// [design/rpm_sequencer.sv]
// rpm_sequencer: operating-mode register, oscillator/synth enables,
// lock pin and buffered clock, written over a serial config port
// assumes link_sck_in is the host's serial clock, idle outside frames
`default_nettype none
module rpm_sequencer #(
  parameter int unsigned CNT_W          = rpm_pkg::TIMER_W,
  parameter int unsigned XTAL_READY_CYC = rpm_pkg::XTAL_READY_CYC,
  parameter int unsigned PLL_LOCK_CYC   = rpm_pkg::PLL_LOCK_CYC,
  parameter int unsigned SEQ_TOTAL_CYC  = rpm_pkg::SEQ_TOTAL_CYC
) (
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic       link_sck_in,
  input  wire logic       config_port_select_n_in,
  input  wire logic       sdi_in,
  output var  logic       sdo_out,
  output var  logic       sdo_oe_out,
  output var  logic [2:0] mode_out,
  output var  logic       osc_en_out,
  output var  logic       pll_en_out,
  output var  logic       rx_en_out,
  output var  logic       tx_en_out,
  output var  logic       lock_pin_out,
  output var  logic       clk_buf_out
);
  // link side: runs on the host serial clock only while a frame is open
  logic [3:0]              bit_cnt;
  logic [14:0]             shift;
  logic [7:0]              rd_shift;
  logic                    sdo_drive;
  rpm_pkg::rpm_cfg_frame_t wr_hold;
  logic                    wr_toggle;
  logic [2:0]              mode_shadow;
  logic                    lock_dis_shadow;
  logic                    unlock_s1;
  logic                    unlock_s2;
  logic                    pll_locked;

  wire [7:0] first_byte = {shift[6:0], sdi_in};
  wire       rd_req     = first_byte[7];
  wire [6:0] rd_addr    = first_byte[6:0];
  wire       addr_done  = (bit_cnt == rpm_pkg::FRAME_ADDR_LAST);
  wire       data_done  = (bit_cnt == rpm_pkg::FRAME_DATA_LAST);
  wire rpm_pkg::rpm_cfg_frame_t frame_now = {shift, sdi_in};
  wire       wr_done    = data_done && !frame_now.rd;
  wire [7:0] rd_main    = {mode_shadow, 5'h00};
  wire [7:0] rd_lock    = {6'h00, unlock_s2, lock_dis_shadow};
  wire [7:0] rd_value   =
    (rd_addr == rpm_pkg::ADDR_MAIN_CONFIG_ZERO) ? rd_main :
    (rd_addr == rpm_pkg::ADDR_LOCK_CTRL)        ? rd_lock : 8'h00;

  always_ff @(posedge link_sck_in) begin
    shift <= {shift[13:0], sdi_in};
  end

  // deselect ends the frame even though the serial clock has stopped
  always_ff @(posedge link_sck_in or posedge config_port_select_n_in) begin
    if (config_port_select_n_in) begin
      bit_cnt   <= 4'h0;
      rd_shift  <= 8'h00;
      sdo_drive <= 1'b0;
    end else begin
      bit_cnt   <= bit_cnt + 4'h1;
      rd_shift  <= addr_done ? rd_value : {rd_shift[6:0], 1'b0};
      sdo_drive <= addr_done ? rd_req : sdo_drive;
    end
  end

  assign sdo_out    = rd_shift[7];
  assign sdo_oe_out = sdo_drive && !config_port_select_n_in;

  // write capture: hold word is stable before the toggle can be seen
  always_ff @(posedge link_sck_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_hold         <= '0;
      wr_toggle       <= 1'b0;
      mode_shadow     <= rpm_pkg::MODE_RESET;
      lock_dis_shadow <= rpm_pkg::LOCK_DIS_RESET;
      unlock_s1       <= 1'b1;
      unlock_s2       <= 1'b1;
    end else begin
      unlock_s1 <= !pll_locked;
      unlock_s2 <= unlock_s1;
      if (wr_done) begin
        wr_hold   <= frame_now;
        wr_toggle <= !wr_toggle;
        if (frame_now.addr == rpm_pkg::ADDR_MAIN_CONFIG_ZERO) begin
          mode_shadow <= frame_now.data[rpm_pkg::MODE_MSB:rpm_pkg::MODE_LSB];
        end
        if (frame_now.addr == rpm_pkg::ADDR_LOCK_CTRL) begin
          lock_dis_shadow <= frame_now.data[rpm_pkg::LOCK_DISABLE_BIT];
        end
      end
    end
  end

  // master side: toggle crossing, then the mode register
  logic       tog_s1;
  logic       tog_s2;
  logic       tog_s3;
  logic [2:0] mode;
  logic       lock_dis;
  logic       xtal_ready;

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else begin
      tog_s1 <= wr_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  wire       wr_evt    = tog_s2 ^ tog_s3;
  wire [2:0] wr_mode   = wr_hold.data[rpm_pkg::MODE_MSB:rpm_pkg::MODE_LSB];
  // codes above transmit are undefined and leave the mode alone
  wire       mode_ok   = (wr_mode <= rpm_pkg::MODE_TX);
  wire       wr_main   = wr_evt && !wr_hold.rd && mode_ok &&
                         (wr_hold.addr == rpm_pkg::ADDR_MAIN_CONFIG_ZERO);
  wire       wr_lock   = wr_evt && !wr_hold.rd &&
                         (wr_hold.addr == rpm_pkg::ADDR_LOCK_CTRL);
  wire [2:0] next_mode = wr_main ? wr_mode : mode;
  wire       next_lock_dis =
    wr_lock ? wr_hold.data[rpm_pkg::LOCK_DISABLE_BIT] : lock_dis;
  wire next_osc_en = (next_mode != rpm_pkg::MODE_SLEEP);
  wire next_pll_en = (next_mode >= rpm_pkg::MODE_SYNTH);
  wire next_rx_en  = (next_mode == rpm_pkg::MODE_RX);
  wire next_tx_en  = (next_mode == rpm_pkg::MODE_TX);

  // enables register together with the mode, no extra cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      mode       <= rpm_pkg::MODE_RESET;
      lock_dis   <= rpm_pkg::LOCK_DIS_RESET;
      osc_en_out <= 1'b0;
      pll_en_out <= 1'b0;
      rx_en_out  <= 1'b0;
      tx_en_out  <= 1'b0;
    end else begin
      mode       <= next_mode;
      lock_dis   <= next_lock_dis;
      osc_en_out <= next_osc_en;
      pll_en_out <= next_pll_en;
      rx_en_out  <= next_rx_en;
      tx_en_out  <= next_tx_en;
    end
  end
  assign mode_out = mode;

  // settle models: rx/tx entry trusts the host to wait for lock
  rpm_settle_timer #(.CNT_W(CNT_W), .LIMIT(XTAL_READY_CYC)) u_xtal (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .run_in   (osc_en_out),
    .done_out (xtal_ready)
  );
  rpm_settle_timer #(.CNT_W(CNT_W), .LIMIT(PLL_LOCK_CYC)) u_pll (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .run_in   (pll_en_out && xtal_ready),
    .done_out (pll_locked)
  );

  // buffered clock is half mclk and only runs on a settled crystal
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      lock_pin_out <= 1'b1;
      clk_buf_out  <= 1'b0;
    end else begin
      lock_pin_out <= lock_dis || pll_locked;
      clk_buf_out  <= xtal_ready && osc_en_out && !clk_buf_out;
    end
  end

  // checking helpers: cycles since leaving sleep, since synth run began
  logic [CNT_W-1:0] up_cnt;
  logic [CNT_W-1:0] syn_cnt;
  localparam logic [CNT_W-1:0] CMAX = '1;
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in || !osc_en_out) begin
      up_cnt <= '0;
    end else begin
      up_cnt <= (up_cnt == CMAX) ? up_cnt : up_cnt + CNT_W'(1);
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in || !(pll_en_out && xtal_ready)) begin
      syn_cnt <= '0;
    end else begin
      syn_cnt <= (syn_cnt == CMAX) ? syn_cnt : syn_cnt + CNT_W'(1);
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  property p_sleep_decode;
    (mode == rpm_pkg::MODE_SLEEP) |-> !osc_en_out && !pll_en_out;
  endproperty
  a_sleep_decode: assert property (p_sleep_decode)
    else $error("sleep mode left an oscillator enabled");

  property p_xtal_ready;
    (up_cnt >= CNT_W'(XTAL_READY_CYC)) |-> xtal_ready;
  endproperty
  a_xtal_ready: assert property (p_xtal_ready)
    else $error("crystal not ready within its settle time");

  property p_pll_lock;
    (syn_cnt >= CNT_W'(PLL_LOCK_CYC)) && pll_en_out |-> pll_locked;
  endproperty
  a_pll_lock: assert property (p_pll_lock)
    else $error("synthesizer not locked within its settle time");

  property p_lock_pin;
    !lock_dis && $rose(pll_locked) |=> lock_pin_out;
  endproperty
  a_lock_pin: assert property (p_lock_pin)
    else $error("lock pin did not follow lock");

  property p_clk_off;
    (!osc_en_out)[*2] |=> !clk_buf_out;
  endproperty
  a_clk_off: assert property (p_clk_off)
    else $error("buffered clock running in sleep");

  property p_total_seq;
    (up_cnt >= CNT_W'(SEQ_TOTAL_CYC)) && pll_en_out |-> pll_locked;
  endproperty
  a_total_seq: assert property (p_total_seq)
    else $error("power-up sequence exceeded its total time");

  sequence s_lock_dis_write;
    wr_lock && wr_hold.data[rpm_pkg::LOCK_DISABLE_BIT];
  endsequence
  sequence s_pin_forced;
    lock_dis ##1 lock_pin_out;
  endsequence
  property p_lock_force;
    s_lock_dis_write |=> s_pin_forced;
  endproperty
  a_lock_force: assert property (p_lock_force)
    else $error("lock disable did not force the pin high");

  property p_mode_take;
    wr_main |=> (mode == $past(wr_mode)) &&
                (osc_en_out == ($past(wr_mode) != rpm_pkg::MODE_SLEEP));
  endproperty
  a_mode_take: assert property (p_mode_take)
    else $error("mode write not applied with its enables");
endmodule // rpm_sequencer
`default_nettype wire

// [design/rpm_settle_timer.sv]
// rpm_settle_timer: counts cycles while run is high, flags when done
// assumes run comes from logic on the same clock
`default_nettype none
module rpm_settle_timer #(
  parameter int unsigned CNT_W = 20,
  parameter int unsigned LIMIT = 4
) (
  input  wire logic mclk_in,
  input  wire logic rst_b_in,
  input  wire logic run_in,
  output var  logic done_out
);
  localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
  logic [CNT_W-1:0] cnt;
  wire              at_last = (cnt == LIM - ONE);

  // done rises on the LIMIT-th edge that sees run high
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in || !run_in) begin
      cnt      <= '0;
      done_out <= 1'b0;
    end else begin
      cnt      <= (cnt == LIM) ? cnt : cnt + ONE;
      done_out <= done_out | at_last;
    end
  end
endmodule // rpm_settle_timer
`default_nettype wire

// [tb/rpm_host_model.sv]
// rpm_host_model: host side of the serial config port
// assumes the device samples sdi on rising sck, msb first
`default_nettype none
module rpm_host_model (
  output var  logic sck_out,
  output var  logic sel_n_out,
  output var  logic sdi_out,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // output enable seen just before the last rising edge, for the bench
  logic oe_seen = 1'b0;
  // parked levels between frames keep the sleep current low
  initial begin
    sck_out   = 1'b0;
    sel_n_out = 1'b1;
    sdi_out   = 1'b0;
  end
  // sck stands still outside frames; 32 ns period inside one
  task automatic frame(input logic [15:0] w, output logic [7:0] r);
    r = 8'h00;
    #7 sel_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi_out = w[i];
      #16;
      if (i < 8) r[i] = sdo_in;
      if (i == 0) oe_seen = sdo_oe_in;
      sck_out = 1'b1;
      #16 sck_out = 1'b0;
    end
    sdi_out = 1'b0;
    #16 sel_n_out = 1'b1;
    // gap well above the 4 mclk spacing between writes
    #200;
  endtask
endmodule // rpm_host_model
`default_nettype wire

// [tb/tb.sv]
// tb: scenario bench for the radio power-mode sequencer
// assumes shortened settle counts so the run stays short
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned XC = 40;
  localparam int unsigned PC = 10;
  // total budget leaves room for the two host frames on top of the settles
  localparam int unsigned SC = 200;
  logic       mclk_in  = 1'b0;
  logic       rst_b_in = 1'b1;
  wire  logic sck, sel_n, sdi, sdo, oe, osc, pll, rx, tx, lock, cbuf;
  wire  logic [2:0] mode;
  int         fail_count  = 0;
  int         checks_done = 0;
  int         c1;
  int         c2;
  int         cyc = 0;
  int         t_up;
  logic [7:0] rd;
  always #10 mclk_in = ~mclk_in;
  always @(posedge mclk_in) cyc <= cyc + 1;
  rpm_sequencer #(.XTAL_READY_CYC(XC), .PLL_LOCK_CYC(PC),
    .SEQ_TOTAL_CYC(SC)) u_dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .link_sck_in(sck),
    .config_port_select_n_in(sel_n), .sdi_in(sdi), .sdo_out(sdo),
    .sdo_oe_out(oe), .mode_out(mode), .osc_en_out(osc), .pll_en_out(pll),
    .rx_en_out(rx), .tx_en_out(tx), .lock_pin_out(lock),
    .clk_buf_out(cbuf));
  rpm_host_model u_host (.sck_out(sck), .sel_n_out(sel_n),
    .sdi_out(sdi), .sdo_in(sdo), .sdo_oe_in(oe));
  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // sel 0 waits clk_buf high, 1 lock pin high, else mode == m
  task automatic wait_hi(input int sel, input logic [2:0] m,
                         output int c);
    c = 0;
    while (!((sel == 0) ? (cbuf === 1'b1) : (sel == 1) ? (lock === 1'b1)
             : (mode === m))) begin
      @(negedge mclk_in);
      c++;
      if (c > 100) begin
        fail_count++;
        finish_test();
      end
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.frame({1'b0, a, d}, rd);
  endtask
  task automatic set_mode(input logic [2:0] m);
    wr(rpm_pkg::ADDR_MAIN_CONFIG_ZERO, {m, 5'h00});
    wait_hi(2, m, c1);
  endtask
  task automatic t_reset();
    check({mode, osc, pll, rx, tx}, 8'h00);
    check({7'h00, lock}, 8'h00);
    repeat (6) @(negedge mclk_in) check({7'h00, cbuf}, 8'h00);
  endtask
  task automatic t_standby();
    t_up = cyc;
    set_mode(rpm_pkg::MODE_STANDBY);
    check({6'h00, osc, pll}, 8'h02);
    wait_hi(0, 3'h0, c1);
    check({7'h00, c1 <= XC + 2}, 8'h01);
  endtask
  task automatic t_synth();
    set_mode(rpm_pkg::MODE_SYNTH);
    check({6'h00, osc, pll}, 8'h03);
    wait_hi(1, 3'h0, c2);
    check({7'h00, c2 <= PC + 3}, 8'h01);
    check({7'h00, cyc - t_up <= SC}, 8'h01);
    u_host.frame({1'b1, rpm_pkg::ADDR_LOCK_CTRL, 8'h00}, rd);
    check(rd, 8'h00);
    check({7'h00, u_host.oe_seen}, 8'h01);
  endtask
  // rx and tx only after synth mode with lock seen
  task automatic t_rxtx();
    set_mode(rpm_pkg::MODE_RX);
    check({4'h0, osc, pll, rx, tx}, 8'h0e);
    set_mode(rpm_pkg::MODE_TX);
    check({4'h0, osc, pll, rx, tx}, 8'h0d);
    wr(rpm_pkg::ADDR_MAIN_CONFIG_ZERO, 8'ha0);
    repeat (10) @(negedge mclk_in);
    check({5'h00, mode}, 8'h04);
  endtask
  task automatic t_lockdis();
    set_mode(rpm_pkg::MODE_STANDBY);
    repeat (4) @(negedge mclk_in);
    check({7'h00, lock}, 8'h00);
    wr(rpm_pkg::ADDR_LOCK_CTRL, 8'h01);
    repeat (6) @(negedge mclk_in);
    check({7'h00, lock}, 8'h01);
    check({7'h00, u_host.oe_seen}, 8'h00);
    u_host.frame({1'b1, rpm_pkg::ADDR_LOCK_CTRL, 8'h00}, rd);
    check(rd, 8'h03);
    wr(rpm_pkg::ADDR_LOCK_CTRL, 8'h00);
    repeat (6) @(negedge mclk_in);
    check({7'h00, lock}, 8'h00);
  endtask
  task automatic t_sleep();
    set_mode(rpm_pkg::MODE_SLEEP);
    check({mode, osc, pll, rx, tx}, 8'h00);
    repeat (3) @(negedge mclk_in);
    // checks start twelve and a half mclk cycles after the mode change, so a one-cycle slip of the gate stays unseen here
    repeat (8) @(negedge mclk_in) check({7'h00, cbuf}, 8'h00);
    check({4'h0, oe, sel_n, sck, sdi}, 8'h04);
  endtask
  initial begin
    // a real falling edge, so the link side's async reset fires
    #1 rst_b_in = 1'b0;
    repeat (10) @(negedge mclk_in);
    rst_b_in = 1'b1;
    @(negedge mclk_in);
    t_reset();
    t_standby();
    t_synth();
    t_rxtx();
    t_lockdis();
    t_sleep();
    finish_test();
  end
endmodule // tb
`default_nettype wire
